// >>> sfcfe_fifo.sv
// Parameterised valid/ready FIFO for captured command words
`timescale 1ns/1ps
module sfcfe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW:0]      wr_reg;
	logic [PW:0]      wr_next;
	logic [PW:0]      rd_reg;
	logic [PW:0]      rd_next;
	logic             do_push;
	logic             do_pop;

	// Depth must be a power of two: pointers wrap with one spare bit
	assign in_ready  = (wr_reg[PW] == rd_reg[PW]) ||
	                   (wr_reg[PW-1:0] != rd_reg[PW-1:0]);
	assign out_valid = (wr_reg != rd_reg);
	assign out_data  = mem_reg[rd_reg[PW-1:0]];
	assign do_push   = in_valid && in_ready;
	assign do_pop    = out_valid && out_ready;

	always_comb begin
		wr_next = do_push ? wr_reg + 1'b1 : wr_reg;
		rd_next = do_pop ? rd_reg + 1'b1 : rd_reg;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else if (clk_en) begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// Storage has no reset; only words behind valid pointers are read
	always_ff @(posedge clock) begin
		if (clk_en && do_push) begin
			mem_reg[wr_reg[PW-1:0]] <= in_data;
		end
	end

endmodule : sfcfe_fifo

// >>> sfcfe_host.sv
// Host model driving the serial link of the flash front end
`timescale 1ns/1ps
module sfcfe_host (
	input  wire logic clock,
	input  wire logic so_out,
	input  wire logic so_oe,
	output logic      cs_n,
	output logic      sck,
	output logic      si
);
	initial begin
		cs_n = 1'h1;
		sck  = 1'h0;
		si   = 1'h0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
	endtask : wait_clk
	// Clock stands still outside frames, at the level the last bit left
	task automatic open_frame();
		wait_clk(4);
		cs_n <= 1'h0;
		wait_clk(4);
	endtask : open_frame
	task automatic close_frame();
		wait_clk(4);
		cs_n <= 1'h1;
		si   <= ~si;
		wait_clk(8);
		@(negedge clock);
	endtask : close_frame
	// Four clocks a half period makes the 80 ns link clock
	task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck <= 1'h0;
			si  <= tx[i];
			wait_clk(4);
			sck <= 1'h1;
			// Output only moves after falls, so just past the rise is safe
			@(negedge clock);
			rx[i] = so_oe ? so_out : ~rx[i];
			wait_clk(4);
		end
	endtask : xfer_byte
endmodule : sfcfe_host

// >>> sfcfe_pkg.sv
// Shared constants, field layouts and types of the serial flash command front end
package sfcfe_pkg;

	localparam int OPCODE_W = 8;
	localparam int ADDR_W   = 24;
	localparam int BYTE_W   = 8;

	// Header bytes after the opcode (24-bit page and byte address)
	localparam logic [1:0] HDR_LAST_BYTE = 2'h2;
	localparam logic [2:0] BIT_LAST      = 3'h7;
	localparam logic [2:0] BIT_FIRST     = 3'h0;

	// Address field layout, 528-byte page size
	localparam int PAGE_W       = 13;
	localparam int OFF10_W      = 10;
	localparam int PAGE10_LSB   = 10;
	// Address field layout, 512-byte page size
	localparam int OFF9_W       = 9;
	localparam int PAGE9_LSB    = 9;

	localparam int FIFO_DEPTH   = 8;
	localparam int GRAN_W       = 2;
	localparam int TAG_W        = 2;
	localparam int FIFO_WIDTH   = TAG_W + GRAN_W + OPCODE_W + ADDR_W;

	localparam int SYNC_W       = 5;
	localparam int SYNC_CS      = 4;
	localparam int SYNC_SCK     = 3;
	localparam int SYNC_SI      = 2;
	localparam int SYNC_WP      = 1;
	localparam int SYNC_RST     = 0;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h1F;

	typedef enum logic [1:0] {
		SFCFE_TAG_NONE   = 2'h0,
		SFCFE_TAG_HEADER = 2'h1,
		SFCFE_TAG_SHORT  = 2'h2,
		SFCFE_TAG_DATA   = 2'h3
	} sfcfe_tag_t;

	typedef enum logic [1:0] {
		SFCFE_GRAN_PAGE   = 2'h0,
		SFCFE_GRAN_BLOCK  = 2'h1,
		SFCFE_GRAN_SECTOR = 2'h2,
		SFCFE_GRAN_CHIP   = 2'h3
	} sfcfe_gran_t;

	typedef enum logic [5:0] {
		SFCFE_IDLE  = 6'h01,
		SFCFE_OPC   = 6'h02,
		SFCFE_ADDR  = 6'h04,
		SFCFE_CHECK = 6'h08,
		SFCFE_DATA  = 6'h10,
		SFCFE_DROP  = 6'h20
	} sfcfe_state_t;

endpackage : sfcfe_pkg

// >>> sfcfe_top.sv
// Serial flash command front end: link framing, protection, ready/busy
`timescale 1ns/1ps
module sfcfe_top (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic        cs_n_pin,
	input  wire logic        sck_pin,
	input  wire logic        si_pin,
	output logic             so_out,
	output logic             so_oe,
	input  wire logic        wp_n_pin,
	input  wire logic        wp_n_driven,
	input  wire logic        reset_n_pin,
	output logic             rdy_busy_out,
	output logic             rdy_busy_oe,
	input  wire logic        page_512,
	output logic [7:0]       live_opcode,
	output logic [23:0]      live_addr,
	input  wire logic        op_modifies,
	input  wire logic        op_writes_protection,
	input  wire logic        sector_protected,
	input  wire logic        op_self_timed,
	input  wire logic        op_touches_array,
	input  wire logic        op_touches_buffer,
	input  wire logic        op_buffer_sel,
	input  wire logic        op_reads,
	input  wire logic [1:0]  op_gran,
	input  wire logic        op_done,
	input  wire logic [7:0]  rd_data,
	output logic             rd_data_take,
	output logic             cmd_valid,
	input  wire logic        cmd_ready,
	output logic [1:0]       cmd_tag,
	output logic [1:0]       cmd_gran,
	output logic [7:0]       cmd_opcode,
	output logic [23:0]      cmd_addr,
	output logic [9:0]       buffer_offset_ten_bit,
	output logic [8:0]       buffer_offset_nine_bit,
	output logic [12:0]      page_number_field,
	output logic [9:0]       page_byte_offset_field,
	output logic [12:0]      flat_page_field,
	output logic [8:0]       flat_byte_field,
	output logic             busy,
	output logic             refused,
	output logic             overrun,
	output logic             op_abort
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	logic [4:0]   sync1_reg;
	logic [4:0]   sync2_reg;
	logic         sck_prev_reg;
	logic         cs_prev_reg;
	logic         wp_level;
	logic         cs_s;
	logic         sck_s;
	logic         si_s;
	logic         wp_active;
	logic         pin_reset;
	logic         sck_rise;
	logic         sck_fall;
	logic         cs_fall;
	logic         cs_rise;

	// Floating write protect reads as released
	assign wp_level  = wp_n_driven ? wp_n_pin : 1'b1;
	assign cs_s      = sync2_reg[sfcfe_pkg::SYNC_CS];
	assign sck_s     = sync2_reg[sfcfe_pkg::SYNC_SCK];
	assign si_s      = sync2_reg[sfcfe_pkg::SYNC_SI];
	assign wp_active = !sync2_reg[sfcfe_pkg::SYNC_WP];
	assign pin_reset = !sync2_reg[sfcfe_pkg::SYNC_RST];
	assign sck_rise  = sck_s && !sck_prev_reg;
	assign sck_fall  = !sck_s && sck_prev_reg;
	assign cs_fall   = !cs_s && cs_prev_reg;
	assign cs_rise   = cs_s && !cs_prev_reg;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync1_reg    <= sfcfe_pkg::SYNC_RESET;
			sync2_reg    <= sfcfe_pkg::SYNC_RESET;
			sck_prev_reg <= 1'b1;
			cs_prev_reg  <= 1'b1;
		end else if (clk_en) begin
			sync1_reg    <= {cs_n_pin, sck_pin, si_pin, wp_level, reset_n_pin};
			sync2_reg    <= sync1_reg;
			sck_prev_reg <= sck_s;
			cs_prev_reg  <= cs_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer

	sfcfe_pkg::sfcfe_state_t state_reg;
	sfcfe_pkg::sfcfe_state_t state_next;
	logic [7:0]   byte_reg;
	logic [7:0]   byte_next;
	logic [2:0]   bit_reg;
	logic [2:0]   bit_next;
	logic [1:0]   hdr_reg;
	logic [1:0]   hdr_next;
	logic [7:0]   opcode_reg;
	logic [7:0]   opcode_next;
	logic [23:0]  addr_reg;
	logic [23:0]  addr_next;
	logic         reads_reg;
	logic         reads_next;
	logic         timed_reg;
	logic         timed_next;
	logic         busy_reg;
	logic         busy_next;
	logic         busy_buf_reg;
	logic         busy_buf_next;
	logic         refused_reg;
	logic         refused_next;
	logic         overrun_reg;
	logic         overrun_next;
	logic [2:0]   obit_reg;
	logic [2:0]   obit_next;
	logic [7:0]   oshift_reg;
	logic [7:0]   oshift_next;
	logic         so_reg;
	logic         so_next;
	logic         take_reg;
	logic         take_next;
	logic         refuse;
	logic         start_op;
	logic         push_valid;
	logic [35:0]  push_word;
	logic         push_ready;
	logic [7:0]   in_byte;

	// MSB first: each new bit enters at the bottom
	assign in_byte = {byte_reg[6:0], si_s};

	// Protection and busy checks made once the address is whole, or as an opcode-only frame ends
	assign refuse = (wp_active && op_modifies && sector_protected)
	             || (wp_active && op_writes_protection)
	             || (busy_reg && op_touches_array)
	             || (busy_reg && op_touches_buffer &&
	                 (op_buffer_sel == busy_buf_reg));

	// Level, not edge: a select rise seen during CHECK must still end DATA
	assign start_op = cs_s && timed_reg &&
	                  (state_reg == sfcfe_pkg::SFCFE_DATA) && !pin_reset;

	always_comb begin
		state_next   = state_reg;
		byte_next    = byte_reg;
		bit_next     = bit_reg;
		hdr_next     = hdr_reg;
		opcode_next  = opcode_reg;
		addr_next    = addr_reg;
		reads_next   = reads_reg;
		timed_next   = timed_reg;
		refused_next = 1'b0;
		overrun_next = overrun_reg;
		push_valid   = 1'b0;
		push_word    = '0;
		if (pin_reset) begin
			state_next = sfcfe_pkg::SFCFE_DROP;
			timed_next = 1'b0;
			reads_next = 1'b0;
		end else begin
			case (state_reg)
				sfcfe_pkg::SFCFE_IDLE: begin
					if (cs_fall) begin
						state_next = sfcfe_pkg::SFCFE_OPC;
						bit_next   = sfcfe_pkg::BIT_FIRST;
						hdr_next   = '0;
						timed_next = 1'b0;
						reads_next = 1'b0;
						addr_next  = '0;
					end
				end
				sfcfe_pkg::SFCFE_OPC,
				sfcfe_pkg::SFCFE_ADDR: begin
					if (cs_rise) begin
						// Opcode-only frame; a partial byte is discarded
						if (state_reg == sfcfe_pkg::SFCFE_ADDR &&
						    hdr_reg == '0 && bit_reg == sfcfe_pkg::BIT_FIRST) begin
							if (refuse || !push_ready) begin
								refused_next = refuse;
								overrun_next = overrun_reg || !refuse;
							end else begin
								push_valid = 1'b1;
								push_word  = {sfcfe_pkg::SFCFE_TAG_SHORT, op_gran,
								              opcode_reg, addr_reg};
							end
						end
						state_next = sfcfe_pkg::SFCFE_IDLE;
					end else if (sck_rise) begin
						byte_next = in_byte;
						bit_next  = bit_reg + 1'b1;
						if (bit_reg == sfcfe_pkg::BIT_LAST) begin
							if (state_reg == sfcfe_pkg::SFCFE_OPC) begin
								opcode_next = in_byte;
								state_next  = sfcfe_pkg::SFCFE_ADDR;
							end else begin
								addr_next = {addr_reg[15:0], in_byte};
								hdr_next  = hdr_reg + 1'b1;
								if (hdr_reg == sfcfe_pkg::HDR_LAST_BYTE) begin
									state_next = sfcfe_pkg::SFCFE_CHECK;
								end
							end
						end
					end
				end
				sfcfe_pkg::SFCFE_CHECK: begin
					if (refuse) begin
						refused_next = 1'b1;
						state_next   = sfcfe_pkg::SFCFE_DROP;
					end else if (!push_ready) begin
						overrun_next = 1'b1;
						state_next   = sfcfe_pkg::SFCFE_DROP;
					end else begin
						push_valid = 1'b1;
						push_word  = {sfcfe_pkg::SFCFE_TAG_HEADER, op_gran,
						              opcode_reg, addr_reg};
						reads_next = op_reads;
						timed_next = op_self_timed;
						state_next = sfcfe_pkg::SFCFE_DATA;
					end
				end
				sfcfe_pkg::SFCFE_DATA: begin
					if (cs_s) begin
						state_next = sfcfe_pkg::SFCFE_IDLE;
						reads_next = 1'b0;
						timed_next = 1'b0;
					end else if (sck_rise && !reads_reg) begin
						byte_next = in_byte;
						bit_next  = bit_reg + 1'b1;
						if (bit_reg == sfcfe_pkg::BIT_LAST) begin
							if (push_ready) begin
								push_valid = 1'b1;
								push_word  = {sfcfe_pkg::SFCFE_TAG_DATA, op_gran,
								              opcode_reg, 16'h0000, in_byte};
							end else begin
								overrun_next = 1'b1;
							end
						end
					end
				end
				sfcfe_pkg::SFCFE_DROP: begin
					// Waits for select high so the next frame starts cleanly
					if (cs_s) begin
						state_next = sfcfe_pkg::SFCFE_IDLE;
					end
				end
				default: begin
					state_next = sfcfe_pkg::SFCFE_DROP;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Busy tracking and serial output

	always_comb begin
		busy_next     = busy_reg;
		busy_buf_next = busy_buf_reg;
		if (op_done || pin_reset) begin
			busy_next = 1'b0;
		end
		if (start_op) begin
			busy_next     = 1'b1;
			busy_buf_next = op_buffer_sel;
		end
		obit_next   = obit_reg;
		oshift_next = oshift_reg;
		so_next     = so_reg;
		take_next   = 1'b0;
		if (state_reg != sfcfe_pkg::SFCFE_DATA || !reads_reg) begin
			obit_next = sfcfe_pkg::BIT_FIRST;
		end else if (sck_fall) begin
			obit_next = obit_reg + 1'b1;
			if (obit_reg == sfcfe_pkg::BIT_FIRST) begin
				so_next     = rd_data[7];
				oshift_next = {rd_data[6:0], 1'b0};
				take_next   = 1'b1;
			end else begin
				so_next     = oshift_reg[7];
				oshift_next = {oshift_reg[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= sfcfe_pkg::SFCFE_DROP;
			byte_reg     <= '0;
			bit_reg      <= '0;
			hdr_reg      <= '0;
			opcode_reg   <= '0;
			addr_reg     <= '0;
			reads_reg    <= 1'b0;
			timed_reg    <= 1'b0;
			busy_reg     <= 1'b0;
			busy_buf_reg <= 1'b0;
			refused_reg  <= 1'b0;
			overrun_reg  <= 1'b0;
			obit_reg     <= '0;
			oshift_reg   <= '0;
			so_reg       <= 1'b0;
			take_reg     <= 1'b0;
		end else if (clk_en) begin
			state_reg    <= state_next;
			byte_reg     <= byte_next;
			bit_reg      <= bit_next;
			hdr_reg      <= hdr_next;
			opcode_reg   <= opcode_next;
			addr_reg     <= addr_next;
			reads_reg    <= reads_next;
			timed_reg    <= timed_next;
			busy_reg     <= busy_next;
			busy_buf_reg <= busy_buf_next;
			refused_reg  <= refused_next;
			overrun_reg  <= overrun_next;
			obit_reg     <= obit_next;
			oshift_reg   <= oshift_next;
			so_reg       <= so_next;
			take_reg     <= take_next;
		end
	end

	// Open drain: only ever drives low, released the cycle work ends
	assign rdy_busy_out = 1'b0;
	assign rdy_busy_oe  = busy_reg && !op_done && !pin_reset;
	assign so_out       = so_reg;
	assign so_oe        = (state_reg == sfcfe_pkg::SFCFE_DATA) && reads_reg &&
	                      !cs_s;
	assign live_opcode  = opcode_reg;
	assign live_addr    = addr_reg;
	assign rd_data_take = take_reg;
	assign busy         = busy_reg;
	assign refused      = refused_reg;
	assign overrun      = overrun_reg;
	assign op_abort     = pin_reset && busy_reg;

	////////////////////////////////////////////////////////////////////////
	// Command FIFO and address split

	logic [35:0]  head_word;

	sfcfe_fifo #(
		.WIDTH (sfcfe_pkg::FIFO_WIDTH),
		.DEPTH (sfcfe_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.resetn    (resetn),
		.clk_en    (clk_en),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (cmd_valid),
		.out_ready (cmd_ready),
		.out_data  (head_word)
	);

	assign {cmd_tag, cmd_gran, cmd_opcode, cmd_addr} = head_word;
	assign buffer_offset_ten_bit  = cmd_addr[sfcfe_pkg::OFF10_W-1:0];
	assign buffer_offset_nine_bit = cmd_addr[sfcfe_pkg::OFF9_W-1:0];
	assign page_number_field      = cmd_addr[sfcfe_pkg::PAGE10_LSB +:
	                                sfcfe_pkg::PAGE_W];
	assign page_byte_offset_field = cmd_addr[sfcfe_pkg::OFF10_W-1:0];
	assign flat_page_field        = cmd_addr[sfcfe_pkg::PAGE9_LSB +:
	                                sfcfe_pkg::PAGE_W];
	assign flat_byte_field        = cmd_addr[sfcfe_pkg::OFF9_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn || !clk_en);

	sequence s_check_refused;
		(state_reg == sfcfe_pkg::SFCFE_CHECK) && refuse && !pin_reset;
	endsequence

	sequence s_dropped;
		!push_valid ##1 (state_reg == sfcfe_pkg::SFCFE_DROP);
	endsequence

	a_so_fall_only: assert property ($changed(so_out) |-> $past(sck_fall))
		else $error("serial output changed without a falling clock edge");
	a_wp_sector_block: assert property (
		s_check_refused and (wp_active && op_modifies && sector_protected)
		|-> s_dropped)
		else $error("protected sector program was not dropped");
	a_wp_prot_reg: assert property (
		(state_reg == sfcfe_pkg::SFCFE_CHECK && wp_active &&
		 op_writes_protection && !pin_reset) |-> s_dropped)
		else $error("protection register change passed write protect");
	a_wp_pullup: assert property (!wp_n_driven [*3] |-> !wp_active)
		else $error("floating write protect read as asserted");
	a_reset_drop: assert property (pin_reset |=>
		(state_reg == sfcfe_pkg::SFCFE_DROP) && !busy_reg)
		else $error("reset pin did not abort the sequencer");
	a_busy_pin: assert property (
		start_op |=> rdy_busy_oe || op_done || pin_reset)
		else $error("ready/busy not pulled low after self-timed start");
	a_busy_array: assert property (
		(state_reg == sfcfe_pkg::SFCFE_CHECK && busy_reg &&
		 op_touches_array && !pin_reset) |-> s_dropped)
		else $error("array access accepted while busy");
	a_frame_start: assert property (
		(state_reg == sfcfe_pkg::SFCFE_IDLE && !cs_fall) |=>
		(state_reg != sfcfe_pkg::SFCFE_OPC))
		else $error("frame opened without select falling");
	a_so_tristate: assert property (
		(cs_s && !pin_reset && state_reg == sfcfe_pkg::SFCFE_DATA) |=>
		(state_reg == sfcfe_pkg::SFCFE_IDLE) && !so_oe)
		else $error("serial output driven while deselected");
	a_release_now: assert property (
		(op_done && busy_reg && !start_op) |-> !rdy_busy_oe ##1 !busy_reg)
		else $error("ready/busy not released when operation ended");

endmodule : sfcfe_top

// >>> sfcfe_top_tb.sv
// Self-checking bench of the serial flash command front end
`timescale 1ns/1ps
module sfcfe_top_tb;
	logic        clock, resetn, cs_n_pin, sck_pin, si_pin, so_out, so_oe;
	logic        wp_n_pin, wp_n_driven, reset_n_pin, rdy_busy_out;
	logic        rdy_busy_oe, op_modifies, op_writes_protection;
	logic        sector_protected, op_self_timed, op_touches_array;
	logic        op_touches_buffer, op_buffer_sel, op_reads, op_done;
	logic        rd_data_take, cmd_valid, cmd_ready, busy, refused;
	logic        overrun, op_abort;
	logic [1:0]  op_gran, cmd_tag, cmd_gran;
	logic [7:0]  live_opcode, rd_data, cmd_opcode, rx;
	logic [23:0] live_addr, cmd_addr;
	logic [9:0]  off10, pbo;
	logic [8:0]  off9, fbyte;
	logic [12:0] pnum, fpage;
	int          bad_count, num_checks, ref_cnt, cyc, r0, abort_cnt, take_cnt;
	// Refuse, wp driven, wp level, array, buffer, select, modifies,
	// writes protection, sector protected
	logic [8:0]  cases [7] = '{9'h1E0, 9'h1D0, 9'h0D8, 9'h185, 9'h182,
		9'h084, 9'h005};

	sfcfe_top i_sfcfe_top (.clock(clock), .resetn(resetn), .clk_en(1'h1),
		.cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
		.so_out(so_out), .so_oe(so_oe), .wp_n_pin(wp_n_pin),
		.wp_n_driven(wp_n_driven), .reset_n_pin(reset_n_pin),
		.rdy_busy_out(rdy_busy_out), .rdy_busy_oe(rdy_busy_oe),
		.page_512(1'h0), .live_opcode(live_opcode), .live_addr(live_addr),
		.op_modifies(op_modifies), .op_writes_protection(op_writes_protection),
		.sector_protected(sector_protected), .op_self_timed(op_self_timed),
		.op_touches_array(op_touches_array), .op_reads(op_reads),
		.op_touches_buffer(op_touches_buffer), .op_buffer_sel(op_buffer_sel),
		.op_gran(op_gran), .op_done(op_done), .rd_data(rd_data),
		.rd_data_take(rd_data_take), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_tag(cmd_tag), .cmd_gran(cmd_gran),
		.cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
		.buffer_offset_ten_bit(off10), .buffer_offset_nine_bit(off9),
		.page_number_field(pnum), .page_byte_offset_field(pbo),
		.flat_page_field(fpage), .flat_byte_field(fbyte), .busy(busy),
		.refused(refused), .overrun(overrun), .op_abort(op_abort));

	sfcfe_host i_sfcfe_host (.clock(clock), .so_out(so_out), .so_oe(so_oe),
		.cs_n(cs_n_pin), .sck(sck_pin), .si(si_pin));

	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (refused === 1'h1) ref_cnt++;
		if (op_abort === 1'h1) abort_cnt++;
		if (rd_data_take === 1'h1) take_cnt++;
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask : chk
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic pop(input logic [1:0] tag, input logic [7:0] op,
		input logic [23:0] a);
		int k;
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (cmd_valid !== 1'h1 && k < 40);
		chk(cmd_tag, tag);
		if (tag == 2'h3) chk(cmd_addr[7:0], a[7:0]);
		else begin
			chk(cmd_opcode, op);
			chk(cmd_addr, a);
			chk(cmd_gran, op_gran);
			chk(off10, a[9:0]);
			chk(off9, a[8:0]);
			chk({pnum, pbo}, a[22:0]);
			chk({fpage, fbyte}, a[21:0]);
		end
		@(posedge clock);
		cmd_ready <= 1'h1;
		@(posedge clock);
		cmd_ready <= 1'h0;
	endtask : pop
	task automatic wait_busy(input logic e);
		int k;
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (busy !== e && k < 20);
		chk(busy, e);
		chk(rdy_busy_oe, e);
		chk(rdy_busy_out, 1'h0);
	endtask : wait_busy
	task automatic send_hdr(input logic [7:0] op, input logic [23:0] a);
		i_sfcfe_host.open_frame();
		i_sfcfe_host.xfer_byte(op, rx);
		i_sfcfe_host.xfer_byte(a[23:16], rx);
		i_sfcfe_host.xfer_byte(a[15:8], rx);
		i_sfcfe_host.xfer_byte(a[7:0], rx);
	endtask : send_hdr
	task automatic run_hdr(input logic [7:0] op, input logic e);
		r0 = ref_cnt;
		send_hdr(op, 24'h020384);
		i_sfcfe_host.close_frame();
		chk(ref_cnt - r0, e);
		if (e === 1'h0) pop(2'h1, op, 24'h020384);
	endtask : run_hdr
	task automatic set_cfg(input logic [8:0] c);
		@(posedge clock);
		{wp_n_driven, wp_n_pin, op_touches_array, op_touches_buffer,
			op_buffer_sel, op_modifies, op_writes_protection,
			sector_protected} <= c[7:0];
		op_self_timed <= 1'h0;
	endtask : set_cfg

	////////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'h0;
		cmd_ready = 1'h0;
		op_done = 1'h0;
		reset_n_pin = 1'h1;
		rd_data = 8'hC3;
		op_reads = 1'h0;
		op_gran = 2'h0;
		op_self_timed = 1'h0;
		{wp_n_driven, wp_n_pin, op_touches_array, op_touches_buffer,
			op_buffer_sel, op_modifies, op_writes_protection,
			sector_protected} = 8'hC0;
		repeat (10) @(posedge clock);
		resetn <= 1'h1;
		repeat (5) @(posedge clock);
		// Self-timed write holding buffer 0, one data byte
		set_cfg(9'h0D4);
		op_gran <= 2'h2;
		@(posedge clock);
		op_self_timed <= 1'h1;
		send_hdr(8'hA5, 24'h123656);
		i_sfcfe_host.xfer_byte(8'h3C, rx);
		i_sfcfe_host.close_frame();
		pop(2'h1, 8'hA5, 24'h123656);
		pop(2'h3, 8'h00, 24'h00003C);
		wait_busy(1'h1);
		$display("Test write done");
		// Busy blocking, then write protect, then floating protect pin
		for (int i = 0; i < 7; i++) begin
			if (i == 3) begin
				@(posedge clock);
				op_done <= 1'h1;
				@(posedge clock);
				op_done <= 1'h0;
				wait_busy(1'h0);
			end
			set_cfg(cases[i]);
			op_gran <= i[1:0];
			run_hdr(8'h10 + i[7:0], cases[i][8]);
		end
		$display("Test protection done");
		// Stalled consumer: eight words fit, the ninth is lost
		set_cfg(9'h0C0);
		for (int i = 0; i < 9; i++) begin
			if (i == 8) chk(overrun, 1'h0);
			i_sfcfe_host.open_frame();
			i_sfcfe_host.xfer_byte(i[7:0], rx);
			i_sfcfe_host.close_frame();
		end
		chk(overrun, 1'h1);
		for (int i = 0; i < 8; i++) pop(2'h2, i[7:0], 24'h0);
		@(negedge clock);
		chk(cmd_valid, 1'h0);
		$display("Test fifo done");
		// Reset pin aborts busy work and discards a cut frame
		@(posedge clock);
		op_self_timed <= 1'h1;
		run_hdr(8'h77, 1'h0);
		wait_busy(1'h1);
		@(posedge clock);
		reset_n_pin <= 1'h0;
		wait_busy(1'h0);
		@(posedge clock);
		op_self_timed <= 1'h0;
		reset_n_pin <= 1'h1;
		i_sfcfe_host.open_frame();
		i_sfcfe_host.xfer_byte(8'h55, rx);
		i_sfcfe_host.xfer_byte(8'h01, rx);
		reset_n_pin <= 1'h0;
		repeat (4) @(posedge clock);
		reset_n_pin <= 1'h1;
		i_sfcfe_host.xfer_byte(8'h02, rx);
		i_sfcfe_host.xfer_byte(8'h03, rx);
		i_sfcfe_host.close_frame();
		chk(cmd_valid, 1'h0);
		chk(abort_cnt, 1);
		$display("Test reset pin done");
		// Read: first byte shifted out on falls, MSB first
		@(posedge clock);
		op_reads <= 1'h1;
		send_hdr(8'h0B, 24'h000200);
		i_sfcfe_host.xfer_byte(8'h00, rx);
		@(negedge clock);
		chk(so_oe, 1'h1);
		chk(rx, 8'hC3);
		chk(live_opcode, 8'h0B);
		chk(live_addr, 24'h000200);
		i_sfcfe_host.close_frame();
		chk(so_oe, 1'h0);
		chk(take_cnt, 1);
		$display("Test read done");
		give_verdict();
	end
endmodule : sfcfe_top_tb
